// ### hw/fcim_coil_input_map.sv
// Purpose: coil and discrete input spaces of the embedded fieldbus slave
// Assumes: frame parser on the same clock hands over decoded requests
// Notes: configuration and state over AXI4-Lite
//
// Function
// (R1) profile setting: 0 standard default, 1 alternate
// (R2) alternate profile gives 32-bit control/status words; the control word here keeps 16 bits, bits 31-16 read zero
// (R3) function code selects space; address within it
// (R4) message addresses are zero-based reference numbers
// (R5) coil 33 travels as address 0032
// (R6) first 32 coils map control word bits
// (R7) relay outputs follow from coil 00033 onward
// (R8) standard bits 0-2 active-low offs, 3 start
// (R9) standard 5,6 ramp holds, 7 reset, 11 location
// (R10) alternate bits 0-4 stop start reverse local reset
// (R11) alternate 5 location, 6 inhibit, 7-9 stop modes
// (R12) alternate bits 10-15 ramp, lock, torque commands
// (R13) coil reads always return current state
// (R14) coil writes only under fieldbus control
// (R15) coil function codes 01, 05, 0x0F
// (R16) first 32 discrete inputs map status word
// (R17) digital inputs follow from discrete input 33
// (R18) discrete inputs read with function 0x02
// (R19) refused coil writes answer with exception
// (R20) reserved or unused positions read as zero
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "fcim_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module fcim_coil_input_map #(
  parameter int N_RELAY = 6,
  parameter int N_DIN = 6,
  parameter int MAX_BITS = 64
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // request from the frame parser
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_qty_i,
  input wire logic [MAX_BITS-1:0] req_wdata_i,
  // answer to the frame builder
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_func_o,
  output logic rsp_exc_o,
  output logic [7:0] rsp_exc_code_o,
  output logic [MAX_BITS-1:0] rsp_data_o,
  // drive side
  input wire logic [31:0] status_word_i,
  input wire logic [N_DIN-1:0] din_i,
  output logic [N_RELAY-1:0] relay_o,
  output logic [31:0] ctrl_word_o,
  output logic profile_select_o,
  output logic off_one_n_o,
  output logic off_two_n_o,
  output logic off_three_n_o,
  output logic start_o,
  output logic ramp_freeze_n_o,
  output logic ramp_input_clamp_n_o,
  output logic fault_reset_o,
  output logic ext_location_two_o,
  output logic stop_o,
  output logic reverse_o,
  output logic local_o,
  output logic run_inhibit_o,
  output logic stop_by_ramp_o,
  output logic stop_emergency_o,
  output logic stop_by_coast_o,
  output logic second_accel_set_o,
  output logic ramp_output_clear_o,
  output logic ramp_freeze_o,
  output logic ramp_input_clear_alt_o,
  output logic lock_local_request_o,
  output logic second_torque_limit_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  localparam int COIL_N = `FCIM_WORD_BITS + N_RELAY;
  localparam int DI_N = `FCIM_WORD_BITS + N_DIN;
  localparam int IO_N = (N_RELAY > N_DIN) ? N_RELAY : N_DIN;
  localparam int SPC_N = `FCIM_WORD_BITS + IO_N;
  localparam int WIDE_N = SPC_N + MAX_BITS;
  localparam logic [15:0] MAX_QTY = 16'(MAX_BITS);

  if (N_RELAY < 1 || N_RELAY > 32 || N_DIN < 1 || N_DIN > 32 || MAX_BITS < 1
      || MAX_BITS > 2000) begin : g_chk_params
    $error("relay and input counts must lie in 1..32, MAX_BITS in 1..2000");
  end

  fcim_pkg::fcim_profile_e profile;
  logic fb_ctrl_en;
  logic [15:0] ctrl_word;
  logic [N_RELAY-1:0] relay;
  logic [N_DIN-1:0] din_s1, din_s2, din_s3, din_stable;
  logic [15:0] exc_cnt;

  // profile-dependent views of the words
  logic [15:0] ctrl_used;
  logic [31:0] ctrl_read;
  logic [31:0] status_read;
  always_comb begin
    ctrl_used = (profile == fcim_pkg::profile_alternate) ? `FCIM_ALT_CTRL_USED
                                                         : `FCIM_STD_CTRL_USED; // R1
    ctrl_read = {16'h0000, ctrl_word & ctrl_used}; // R20
    status_read = status_word_i & ((profile == fcim_pkg::profile_alternate)
                                   ? `FCIM_ALT_WORD_MASK : `FCIM_STD_WORD_MASK); // R2
  end

  // request decode
  logic do_req, is_coil_space, is_write;
  logic [15:0] eff_qty;
  logic [16:0] end_addr, space_n;
  logic [SPC_N-1:0] space_img;
  logic [MAX_BITS-1:0] qmask, rd_bits, wr_bits;
  logic [WIDE_N-1:0] wide_img, wide_mask, wide_wdata;
  logic [COIL_N-1:0] wmask, writable, coil_img, next_coil_img;
  fcim_pkg::fcim_exc_e exc;

  assign req_ready_o = !rsp_valid_o || rsp_ready_i;
  assign do_req = ce_i && req_valid_i && req_ready_o;

  always_comb begin
    coil_img = {relay, 16'h0000, ctrl_read[15:0]}; // R6 R7 R20
    is_coil_space = (req_func_i != `FCIM_FC_READ_INPUTS); // R3
    is_write = (req_func_i == `FCIM_FC_WRITE_COIL) || (req_func_i == `FCIM_FC_WRITE_COILS);
    eff_qty = (req_func_i == `FCIM_FC_WRITE_COIL) ? 16'h0001 : req_qty_i;
    wr_bits = (req_func_i == `FCIM_FC_WRITE_COIL)
              ? MAX_BITS'(req_wdata_i[15:0] == `FCIM_COIL_ON) : req_wdata_i;
    if (is_coil_space) begin
      space_img = SPC_N'(coil_img);
      space_n = 17'(COIL_N);
    end else begin
      space_img = SPC_N'({din_stable, status_read}); // R16 R17
      space_n = 17'(DI_N);
    end
    // zero-based address counts from the first reference of the space
    end_addr = {1'b0, req_addr_i} + {1'b0, eff_qty}; // R4 R5
    qmask = ~({MAX_BITS{1'b1}} << eff_qty);
    wide_img = {{MAX_BITS{1'b0}}, space_img} >> req_addr_i;
    rd_bits = wide_img[MAX_BITS-1:0] & qmask; // R13
    wide_mask = {{SPC_N{1'b0}}, qmask} << req_addr_i;
    wide_wdata = {{SPC_N{1'b0}}, wr_bits} << req_addr_i;
    wmask = wide_mask[COIL_N-1:0];
    writable = {{N_RELAY{1'b1}}, 16'h0000, ctrl_used}; // R19
    next_coil_img = (coil_img & ~wmask) | (wide_wdata[COIL_N-1:0] & wmask);
    exc = fcim_pkg::exc_none;
    unique case (req_func_i)
      `FCIM_FC_READ_COILS, `FCIM_FC_READ_INPUTS, `FCIM_FC_WRITE_COILS: begin // R15 R18
      end
      `FCIM_FC_WRITE_COIL: begin
        if (req_wdata_i[15:0] != `FCIM_COIL_ON && req_wdata_i[15:0] != `FCIM_COIL_OFF) begin
          exc = fcim_pkg::exc_value;
        end
      end
      default: exc = fcim_pkg::exc_func;
    endcase
    if (exc == fcim_pkg::exc_none) begin
      if (eff_qty == 16'h0000 || eff_qty > MAX_QTY) begin
        exc = fcim_pkg::exc_value;
      end else if (end_addr > space_n) begin
        exc = fcim_pkg::exc_addr; // R3
      end else if (is_write && !fb_ctrl_en) begin
        exc = fcim_pkg::exc_device; // R14 R19
      end else if (is_write && ((wmask & ~writable) != '0)) begin
        exc = fcim_pkg::exc_addr; // R19
      end
    end
  end

  // coil storage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_word <= `FCIM_CTRL_RST;
      relay <= '0;
    end else if (do_req && is_write && exc == fcim_pkg::exc_none) begin // R14
      ctrl_word <= next_coil_img[15:0];
      relay <= next_coil_img[COIL_N-1:`FCIM_WORD_BITS];
    end
  end

  // answer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_func_o <= 8'h00;
      rsp_exc_o <= 1'b0;
      rsp_exc_code_o <= 8'h00;
      rsp_data_o <= '0;
    end else if (ce_i) begin
      if (do_req) begin
        rsp_valid_o <= 1'b1;
        rsp_func_o <= req_func_i;
        rsp_exc_o <= (exc != fcim_pkg::exc_none);
        rsp_exc_code_o <= exc;
        rsp_data_o <= (is_write || exc != fcim_pkg::exc_none) ? '0 : rd_bits;
      end else if (rsp_ready_i) begin
        rsp_valid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      exc_cnt <= 16'h0000;
    end else if (do_req && exc != fcim_pkg::exc_none) begin
      exc_cnt <= exc_cnt + 16'h0001;
    end
  end

  // digital input pins: change accepted once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      din_s1 <= '0;
      din_s2 <= '0;
      din_s3 <= '0;
      din_stable <= '0;
    end else if (ce_i) begin
      din_s1 <= din_i;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      din_stable <= (din_s2 & din_s3) | (din_stable & (din_s2 ^ din_s3)); // R17
    end
  end

  // decoded commands: start, fault reset and location two live in both profiles, each of the rest only in its own
  logic std_p;
  logic alt_p;
  assign std_p = (profile == fcim_pkg::profile_standard);
  assign alt_p = (profile == fcim_pkg::profile_alternate);
  assign relay_o = relay;
  assign ctrl_word_o = ctrl_read;
  assign profile_select_o = profile;
  assign off_one_n_o = !std_p || ctrl_read[0]; // R8
  assign off_two_n_o = !std_p || ctrl_read[1]; // R8
  assign off_three_n_o = !std_p || ctrl_read[2]; // R8
  assign start_o = (std_p && ctrl_read[3]) || (alt_p && ctrl_read[1]); // R8 R10
  assign ramp_freeze_n_o = !std_p || ctrl_read[5]; // R9
  assign ramp_input_clamp_n_o = !std_p || ctrl_read[6]; // R9
  assign fault_reset_o = (std_p && ctrl_read[7]) || (alt_p && ctrl_read[4]); // R9 R10
  assign ext_location_two_o = (std_p && ctrl_read[11]) || (alt_p && ctrl_read[5]); // R9 R11
  assign stop_o = alt_p && ctrl_read[0]; // R10
  assign reverse_o = alt_p && ctrl_read[2]; // R10
  assign local_o = alt_p && ctrl_read[3]; // R10
  assign run_inhibit_o = alt_p && ctrl_read[6]; // R11
  assign stop_by_ramp_o = alt_p && ctrl_read[7]; // R11
  assign stop_emergency_o = alt_p && ctrl_read[8]; // R11
  assign stop_by_coast_o = alt_p && ctrl_read[9]; // R11
  assign second_accel_set_o = alt_p && ctrl_read[10]; // R12
  assign ramp_output_clear_o = alt_p && ctrl_read[11]; // R12
  assign ramp_freeze_o = alt_p && ctrl_read[12]; // R12
  assign ramp_input_clear_alt_o = alt_p && ctrl_read[13]; // R12
  assign lock_local_request_o = alt_p && ctrl_read[14]; // R12
  assign second_torque_limit_o = alt_p && ctrl_read[15]; // R12

  // AXI4-Lite write side
  logic aw_held, w_held, wr_go;
  logic [7:0] aw_addr, wr_addr;
  logic [31:0] w_data, wr_data;
  logic [3:0] w_strb, wr_strb;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data = w_held ? w_data : s_axi_wdata_i;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  assign wr_go = ce_i && !s_axi_bvalid_o && (aw_held || s_axi_awvalid_i)
                 && (w_held || s_axi_wvalid_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `FCIM_AXI_OKAY;
    end else if (ce_i) begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_addr == `FCIM_OFS_CFG) ? `FCIM_AXI_OKAY : `FCIM_AXI_SLVERR;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      profile <= fcim_pkg::fcim_profile_e'(1'(`FCIM_CFG_RST >> `FCIM_CFG_PROFILE_BIT)); // R1
      fb_ctrl_en <= 1'(`FCIM_CFG_RST >> `FCIM_CFG_FB_CTRL_BIT);
    end else if (wr_go && wr_addr == `FCIM_OFS_CFG && wr_strb[0]) begin
      profile <= fcim_pkg::fcim_profile_e'(wr_data[`FCIM_CFG_PROFILE_BIT]); // R1
      fb_ctrl_en <= wr_data[`FCIM_CFG_FB_CTRL_BIT];
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `FCIM_AXI_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `FCIM_AXI_OKAY;
        unique case (s_axi_araddr_i)
          `FCIM_OFS_CFG: s_axi_rdata_o <= {30'h0, fb_ctrl_en, profile};
          `FCIM_OFS_CTRL: s_axi_rdata_o <= ctrl_read;
          `FCIM_OFS_RELAY: s_axi_rdata_o <= 32'(relay);
          `FCIM_OFS_DIN: s_axi_rdata_o <= 32'(din_stable);
          `FCIM_OFS_EXC_CNT: s_axi_rdata_o <= {16'h0000, exc_cnt};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `FCIM_AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### inc/fcim_defines.svh
// Purpose: offsets, field positions, reset values and codes of the coil/input map
// Assumes: included by the package and the design file
// Notes: byte offsets on the register bus
`ifndef FCIM_DEFINES_SVH
`define FCIM_DEFINES_SVH

`define FCIM_OFS_CFG 8'h00
`define FCIM_OFS_CTRL 8'h04
`define FCIM_OFS_RELAY 8'h08
`define FCIM_OFS_DIN 8'h0c
`define FCIM_OFS_EXC_CNT 8'h10

`define FCIM_CFG_PROFILE_BIT 0
`define FCIM_CFG_FB_CTRL_BIT 1
`define FCIM_CFG_RST 2'h0

`define FCIM_CTRL_RST 16'h0000
`define FCIM_WORD_BITS 32
`define FCIM_STD_WORD_MASK 32'h0000_ffff
`define FCIM_ALT_WORD_MASK 32'hffff_ffff
`define FCIM_STD_CTRL_USED 16'h08ef
`define FCIM_ALT_CTRL_USED 16'hffff

`define FCIM_FC_READ_COILS 8'h01
`define FCIM_FC_READ_INPUTS 8'h02
`define FCIM_FC_WRITE_COIL 8'h05
`define FCIM_FC_WRITE_COILS 8'h0f

`define FCIM_COIL_ON 16'hff00
`define FCIM_COIL_OFF 16'h0000

`define FCIM_EXC_FUNC 8'h01
`define FCIM_EXC_ADDR 8'h02
`define FCIM_EXC_VALUE 8'h03
`define FCIM_EXC_DEVICE 8'h04

`define FCIM_AXI_OKAY 2'h0
`define FCIM_AXI_SLVERR 2'h2

`endif

// ### inc/fcim_pkg.sv
// Purpose: types shared by the coil/input map
// Assumes: fcim_defines.svh on the include path
// Notes: none
`include "fcim_defines.svh"

package fcim_pkg;

  typedef enum logic [0:0] {
    profile_standard = 1'b0,
    profile_alternate = 1'b1
  } fcim_profile_e;

  typedef enum logic [7:0] {
    fc_read_coils = `FCIM_FC_READ_COILS,
    fc_read_inputs = `FCIM_FC_READ_INPUTS,
    fc_write_coil = `FCIM_FC_WRITE_COIL,
    fc_write_coils = `FCIM_FC_WRITE_COILS
  } fcim_func_e;

  typedef enum logic [7:0] {
    exc_none = 8'h00,
    exc_func = `FCIM_EXC_FUNC,
    exc_addr = `FCIM_EXC_ADDR,
    exc_value = `FCIM_EXC_VALUE,
    exc_device = `FCIM_EXC_DEVICE
  } fcim_exc_e;

endpackage

// ### verif/fcim_coil_input_map_chk.sv
// Purpose: port checks of the coil/input map
// Assumes: bound to fcim_coil_input_map
// Notes: one clock domain
`timescale 1ns/10ps
`default_nettype none

module fcim_coil_input_map_chk #(
  parameter int N_RELAY = 6,
  parameter int MAX_BITS = 64
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_qty_i,
  input wire logic [MAX_BITS-1:0] req_wdata_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_ready_i,
  input wire logic [7:0] rsp_func_o,
  input wire logic rsp_exc_o,
  input wire logic [7:0] rsp_exc_code_o,
  input wire logic [MAX_BITS-1:0] rsp_data_o,
  input wire logic [31:0] status_word_i,
  input wire logic [N_RELAY-1:0] relay_o,
  input wire logic [31:0] ctrl_word_o,
  input wire logic profile_select_o,
  input wire logic off_one_n_o,
  input wire logic off_two_n_o,
  input wire logic off_three_n_o,
  input wire logic start_o,
  input wire logic ramp_freeze_n_o,
  input wire logic ramp_input_clamp_n_o,
  input wire logic fault_reset_o,
  input wire logic ext_location_two_o,
  input wire logic stop_o,
  input wire logic reverse_o,
  input wire logic local_o,
  input wire logic run_inhibit_o,
  input wire logic stop_by_ramp_o,
  input wire logic stop_emergency_o,
  input wire logic stop_by_coast_o,
  input wire logic second_accel_set_o,
  input wire logic ramp_output_clear_o,
  input wire logic ramp_freeze_o,
  input wire logic ramp_input_clear_alt_o,
  input wire logic lock_local_request_o,
  input wire logic second_torque_limit_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic taken;
  logic [15:0] alt_v;
  logic [7:0] std_v;
  logic [31:0] cw;
  assign taken = ce_i && req_valid_i && req_ready_o;
  assign cw = ctrl_word_o;
  assign alt_v = {second_torque_limit_o, lock_local_request_o, ramp_input_clear_alt_o,
    ramp_freeze_o, ramp_output_clear_o, second_accel_set_o, stop_by_coast_o,
    stop_emergency_o, stop_by_ramp_o, run_inhibit_o, ext_location_two_o, fault_reset_o,
    local_o, reverse_o, start_o, stop_o};
  assign std_v = {ext_location_two_o, fault_reset_o, ramp_input_clamp_n_o, ramp_freeze_n_o,
    start_o, off_three_n_o, off_two_n_o, off_one_n_o};

  rsp_follows_a: assert property (taken |=> rsp_valid_o && rsp_func_o == $past(req_func_i))
    else $error("answer missing or wrong function");
  rsp_stands_a: assert property (rsp_valid_o && !(rsp_ready_i && ce_i) |=>
    rsp_valid_o && $stable(rsp_data_o) && $stable(rsp_exc_code_o))
    else $error("answer dropped or changed");
  bad_func_a: assert property (taken && !(req_func_i inside {8'h01, 8'h02, 8'h05, 8'h0f})
    |=> rsp_exc_o && rsp_exc_code_o == 8'h01)
    else $error("unknown function not refused");
  refused_keep_a: assert property (taken ##1 (rsp_exc_o && $stable(profile_select_o)) |->
    $stable(ctrl_word_o) && $stable(relay_o))
    else $error("coils changed on exception");
  std_map_a: assert property (!profile_select_o |-> std_v == {cw[11], cw[7:5], cw[3:0]}
    && (alt_v & 16'hffcd) == 16'h0 && (cw & ~32'h0000_08ef) == 32'h0)
    else $error("standard control outputs wrong");
  alt_map_a: assert property (profile_select_o |-> alt_v == cw[15:0] && cw[31:16] == 16'h0
    && {ramp_input_clamp_n_o, ramp_freeze_n_o, off_three_n_o, off_two_n_o, off_one_n_o}
    == 5'h1f)
    else $error("alternate control outputs wrong");
  status_std_a: assert property (taken && req_func_i == 8'h02 && req_addr_i == 16'h0 &&
    req_qty_i == 16'h0020 && !profile_select_o |=>
    rsp_data_o[31:0] == {16'h0, $past(status_word_i[15:0])})
    else $error("standard status bits wrong");
  status_alt_a: assert property (taken && req_func_i == 8'h02 && req_addr_i == 16'h0 &&
    req_qty_i == 16'h0020 && profile_select_o |=>
    rsp_data_o[31:0] == $past(status_word_i))
    else $error("alternate status bits wrong");
  relay_one_a: assert property (taken && req_func_i == 8'h05 && req_addr_i == 16'h0020 &&
    req_wdata_i[15:0] == 16'hff00 ##1 !rsp_exc_o |-> relay_o[0])
    else $error("coil 33 did not set relay 1");

  cover property (taken && req_func_i == 8'h0f);
  cover property (rsp_valid_o && rsp_exc_o);
  cover property (taken && profile_select_o);
endmodule

`default_nettype wire

// ### verif/fcim_coil_input_map_tb_top.sv
// Purpose: self-checking bench of the coil/input map
// Assumes: master model and checker compiled first
// Notes: registers reached over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t line %0d got %h exp %h", $time, `__LINE__, g, e); end end

module fcim_coil_input_map_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [31:0] status = 32'h0;
  logic [5:0] din = 6'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, ctrl;
  logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_exc, prof;
  logic [7:0] req_func, rsp_code;
  logic [15:0] req_addr, req_qty;
  logic [63:0] req_wdata, rsp_data;
  logic [5:0] relay;
  bit slow = 1'b0;
  int mismatches = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  fcim_coil_input_map fcim_coil_input_map_i (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_func_i(req_func),
    .req_addr_i(req_addr), .req_qty_i(req_qty), .req_wdata_i(req_wdata),
    .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_func_o(), .rsp_exc_o(rsp_exc),
    .rsp_exc_code_o(rsp_code), .rsp_data_o(rsp_data), .status_word_i(status), .din_i(din),
    .relay_o(relay), .ctrl_word_o(ctrl), .profile_select_o(prof), .off_one_n_o(),
    .off_two_n_o(), .off_three_n_o(), .start_o(), .ramp_freeze_n_o(),
    .ramp_input_clamp_n_o(), .fault_reset_o(), .ext_location_two_o(), .stop_o(),
    .reverse_o(), .local_o(), .run_inhibit_o(), .stop_by_ramp_o(), .stop_emergency_o(),
    .stop_by_coast_o(), .second_accel_set_o(), .ramp_output_clear_o(), .ramp_freeze_o(),
    .ramp_input_clear_alt_o(), .lock_local_request_o(), .second_torque_limit_o(),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  fcim_master_model fcim_master_model_i (.clk_sys_i(clk), .req_ready_i(req_ready),
    .rsp_valid_i(rsp_valid), .rsp_exc_i(rsp_exc), .rsp_exc_code_i(rsp_code),
    .rsp_data_i(rsp_data), .req_valid_o(req_valid), .req_func_o(req_func),
    .req_addr_o(req_addr), .req_qty_o(req_qty), .req_wdata_o(req_wdata),
    .rsp_ready_o(rsp_ready));

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic mb(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
      input logic [63:0] d, input logic [7:0] ec, input logic [63:0] ed);
    logic x;
    logic [7:0] c;
    logic [63:0] v;
    fcim_master_model_i.xfer(f, a, q, d, slow, x, c, v);
    `CHK(x, (ec != 8'h00))
    `CHK(c, ec)
    `CHK(v, ed)
  endtask

  task automatic test_done();
    $display("counts: comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(8'h00, rd, rs);
    `CHK(rd, 32'h0)
    `CHK(prof, 1'b0)
    mb(8'h0f, 16'h0000, 16'h0008, 64'hff, 8'h04, 64'h0);
    mb(8'h01, 16'h0000, 16'h0020, 64'h0, 8'h00, 64'h0);
    $display("test control off done");
    axi_wr(8'h00, 32'h2, rs);
    mb(8'h0f, 16'h0000, 16'h0010, 64'hffff, 8'h02, 64'h0);
    mb(8'h0f, 16'h0000, 16'h0004, 64'hf, 8'h00, 64'h0);
    mb(8'h0f, 16'h0005, 16'h0003, 64'h7, 8'h00, 64'h0);
    mb(8'h05, 16'h000b, 16'h0001, 64'hff00, 8'h00, 64'h0);
    mb(8'h01, 16'h0000, 16'h0020, 64'h0, 8'h00, 64'h08ef);
    mb(8'h05, 16'h0003, 16'h0001, 64'h0, 8'h00, 64'h0);
    `CHK(ctrl, 32'h08e7)
    mb(8'h0f, 16'h0020, 16'h0006, 64'h14, 8'h00, 64'h0);
    mb(8'h05, 16'h0020, 16'h0001, 64'hff00, 8'h00, 64'h0);
    mb(8'h05, 16'h0025, 16'h0001, 64'hff00, 8'h00, 64'h0);
    `CHK(relay, 6'h35)
    mb(8'h01, 16'h001e, 16'h0008, 64'h0, 8'h00, 64'hd4);
    mb(8'h05, 16'h0010, 16'h0001, 64'hff00, 8'h02, 64'h0);
    mb(8'h03, 16'h0000, 16'h0001, 64'h0, 8'h01, 64'h0);
    `CHK({relay, ctrl}, {6'h35, 32'h08e7})
    axi_rd(8'h10, rd, rs);
    `CHK(rd, 32'h4)
    $display("test standard done");
    axi_wr(8'h00, 32'h3, rs);
    `CHK(prof, 1'b1)
    status <= 32'ha5a5_5a5a;
    mb(8'h0f, 16'h0000, 16'h0010, 64'hffff, 8'h00, 64'h0);
    `CHK(ctrl, 32'hffff)
    mb(8'h02, 16'h0000, 16'h0020, 64'h0, 8'h00, 64'ha5a5_5a5a);
    axi_wr(8'h00, 32'h2, rs);
    mb(8'h02, 16'h0000, 16'h0020, 64'h0, 8'h00, 64'h5a5a);
    `CHK(ctrl, 32'h08ef)
    $display("test profiles done");
    din <= 6'h2b;
    repeat (6) @(posedge clk);
    slow = 1'b1;
    mb(8'h02, 16'h0020, 16'h0006, 64'h0, 8'h00, 64'h2b);
    slow = 1'b0;
    axi_wr(8'h00, 32'h0, rs);
    mb(8'h05, 16'h0020, 16'h0001, 64'h0, 8'h04, 64'h0);
    `CHK(relay, 6'h35)
    axi_rd(8'h08, rd, rs);
    `CHK(rd, 32'h35)
    axi_rd(8'h20, rd, rs);
    `CHK({rs, rd}, {2'h2, 32'h0})
    axi_wr(8'h04, 32'h1, rs);
    `CHK(rs, 2'h2)
    $display("test inputs and bus done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule

bind fcim_coil_input_map fcim_coil_input_map_chk #(.N_RELAY(N_RELAY), .MAX_BITS(MAX_BITS))
  fcim_coil_input_map_chk_i (.*);

`default_nettype wire

// ### verif/fcim_master_model.sv
// Purpose: network master issuing decoded coil/input requests
// Assumes: same clock as the map
// Notes: released request lines show inverted values
`timescale 1ns/10ps
`default_nettype none

module fcim_master_model (
  input wire logic clk_sys_i,
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_exc_i,
  input wire logic [7:0] rsp_exc_code_i,
  input wire logic [63:0] rsp_data_i,
  output logic req_valid_o,
  output logic [7:0] req_func_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_qty_o,
  output logic [63:0] req_wdata_o,
  output logic rsp_ready_o
);
  initial begin
    req_valid_o = 1'b0;
    req_func_o = 8'h0;
    req_addr_o = 16'h0;
    req_qty_o = 16'h0;
    req_wdata_o = 64'h0;
    rsp_ready_o = 1'b0;
  end

  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
      input logic [63:0] d, input bit slow, output logic x, output logic [7:0] c,
      output logic [63:0] v);
    @(posedge clk_sys_i);
    req_valid_o <= 1'b1;
    req_func_o <= f;
    req_addr_o <= a;
    req_qty_o <= q;
    req_wdata_o <= d;
    do @(posedge clk_sys_i); while (req_ready_i !== 1'b1);
    req_valid_o <= 1'b0;
    req_func_o <= ~f;
    req_addr_o <= ~a;
    req_qty_o <= ~q;
    req_wdata_o <= ~d;
    if (slow) repeat (4) @(posedge clk_sys_i);
    rsp_ready_o <= 1'b1;
    do @(posedge clk_sys_i); while (rsp_valid_i !== 1'b1);
    x = rsp_exc_i;
    c = rsp_exc_code_i;
    v = rsp_data_i;
    rsp_ready_o <= 1'b0;
  endtask
endmodule

`default_nettype wire
